/* psr_rom.sv */
// Clocked mask ROM read path with programmable chip select
`timescale 1ns/100ps
`default_nettype none

module psr_rom
    import psr_pkg::*;
#(
    parameter int ADDR_W = PSR_ADDR_W,
    parameter int DATA_W = PSR_DATA_W,
    parameter int WORDS = PSR_WORDS,
    // Select code and how many leading bits are ignored, fixed at build
    parameter logic [PSR_SEL_W-1:0] SELECT_CODE = 4'h0,
    parameter logic [PSR_IGN_W-1:0] SELECT_IGNORED = 3'h0,
    // Nonzero picks the standard random-number content
    parameter bit RANDOM_CONTENT = 1'b1
)
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_phase1,
    input wire logic i_phase2,
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_select_code_bit_first,
    input wire logic i_select_code_bit_second,
    input wire logic i_select_code_bit_third,
    input wire logic i_select_code_bit_fourth,
    output logic [DATA_W-1:0] o_data,
    output logic o_selected
);

    // ****************************************************
    // Content
    // ****************************************************
    function automatic logic [DATA_W-1:0] rom_word(input int idx);
        logic [15:0] s;
        s = PSR_LFSR_SEED;
        for (int k = 0; k <= idx; k++)
        begin
            s = s[0] ? ((s >> 1) ^ PSR_LFSR_TAPS) : (s >> 1);
        end
        return s[DATA_W-1:0];
    endfunction

    // Contents are constants; a plain custom image would replace this
    logic [DATA_W-1:0] mem [WORDS];
    genvar g;
    generate
        for (g = 0; g < WORDS; g++)
        begin : g_mem
            // RULE_05 random table
            // RULE_01 word store
            assign mem[g] = RANDOM_CONTENT ? rom_word(g) :
                            DATA_W'(g);
        end
    endgenerate

    // ****************************************************
    // Input synchronisers
    // ****************************************************
    localparam int SYNC_W = ADDR_W + PSR_SEL_W + 2;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    wire [SYNC_W-1:0] pins = {i_phase1, i_phase2, i_address,
        i_select_code_bit_first, i_select_code_bit_second,
        i_select_code_bit_third, i_select_code_bit_fourth};

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    wire ph1 = sync2_q[SYNC_W-1];
    wire ph2 = sync2_q[SYNC_W-2];
    wire [ADDR_W-1:0] addr_s = sync2_q[PSR_SEL_W +: ADDR_W];
    // Bit 3 is the first select input, bit 0 the fourth
    wire [PSR_SEL_W-1:0] sel_s = sync2_q[PSR_SEL_W-1:0];

    // ****************************************************
    // Select compare
    // ****************************************************
    // RULE_04 leading ignore mask
    wire [PSR_SEL_W-1:0] care_mask =
        PSR_SEL_MASK_ALL >> SELECT_IGNORED;
    // RULE_02 code compare
    wire sel_match = ((sel_s ^ SELECT_CODE) & care_mask) == '0;

    // ****************************************************
    // Phase sequencer and output
    // ****************************************************
    psr_state_e state_q;
    psr_state_e state_d;
    logic [ADDR_W-1:0] addr_q;
    logic match_q;
    logic [DATA_W-1:0] data_q;
    logic sel_q;

    // RULE_06 phase ordering
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PSR_IDLE: if (ph1) state_d = PSR_PH1;
            PSR_PH1: if (!ph1 && ph2) state_d = PSR_PH2;
            PSR_PH2: if (!ph2) state_d = PSR_IDLE;
            default: state_d = PSR_IDLE;
        endcase
    end

    wire cycle_done = (state_q == PSR_PH2) && !ph2;

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= PSR_IDLE;
            addr_q <= '0;
            match_q <= 1'b0;
            data_q <= PSR_DATA_OFF;
            sel_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            // Address and select sampled during phase one
            if (state_q == PSR_PH1 && ph1)
            begin
                addr_q <= addr_s;
                match_q <= sel_match;
            end
            if (cycle_done)
            begin
                sel_q <= match_q;
                // RULE_03 drivers off read zero
                data_q <= match_q ? mem[addr_q] : PSR_DATA_OFF;
            end
        end
    end

    assign o_data = data_q;
    assign o_selected = sel_q;

endmodule

`default_nettype wire

/* psr_pkg.sv */
// Constants and types for the programmable select ROM read path
// Operation
// RULE_01 - Hold 2048 four-bit words, 11-bit address
// RULE_02 - Compare four select inputs to fixed code
// RULE_03 - Unselected device drives all outputs to zero
// RULE_04 - Select bits ignorable from first bit onward
// RULE_05 - Standard option stores random number table
// RULE_06 - Word appears after both clock phases complete
package psr_pkg;

    localparam int PSR_ADDR_W = 11;
    localparam int PSR_DATA_W = 4;
    localparam int PSR_WORDS = 2048;
    localparam int PSR_SEL_W = 4;
    // Ignored-bit count runs 0 (all compared) to 4 (always selected)
    localparam int PSR_IGN_W = 3;
    localparam logic [PSR_DATA_W-1:0] PSR_DATA_OFF = 4'h0;
    localparam logic [PSR_SEL_W-1:0] PSR_SEL_MASK_ALL = 4'hf;
    // Random content generator: 16-bit maximal LFSR, arbitrary seed
    localparam logic [15:0] PSR_LFSR_SEED = 16'hace1;
    localparam logic [15:0] PSR_LFSR_TAPS = 16'hb400;

    // Phase sequencer of one read cycle
    typedef enum logic [2:0] {
        PSR_IDLE = 3'b001,
        PSR_PH1 = 3'b010,
        PSR_PH2 = 3'b100
    } psr_state_e;

endpackage

/* psr_rom_properties.sv */
// Select ROM checks
`timescale 1ns/100ps
`default_nettype none
module psr_rom_chk (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_phase1,
    input wire logic i_phase2,
    input wire logic [3:0] o_data,
    input wire logic o_selected
);
    default clocking @(posedge i_clock); endclocking
    a_off_zero: assert property (disable iff (!i_nrst)
        !o_selected |-> o_data == 4'h0) else $error("stray data");
    a_hold_ph1: assert property (disable iff (!i_nrst)
        i_phase1[*6] |-> $stable({o_data, o_selected})) else $error("early");
    a_rst_quiet: assert property (!i_nrst |->
        (o_data == 4'h0 && !o_selected)) else $error("output in reset");
    // Pin phase two falls, two sync stages and the output register later the outputs move
    a_data_after_ph2: assert property (disable iff (!i_nrst)
        $changed(o_data) |-> $past(i_phase2, 4) && !$past(i_phase2, 3))
        else $error("data moved off cycle end");
    a_sel_after_ph2: assert property (disable iff (!i_nrst)
        $changed(o_selected) |-> $past(i_phase2, 4) && !$past(i_phase2, 3))
        else $error("select moved off cycle end");
    a_idle_hold: assert property (disable iff (!i_nrst)
        !i_phase2[*5] |-> $stable({o_data, o_selected}))
        else $error("output moved while idle");
    c_on: cover property (o_selected);
    c_off: cover property ($fell(o_selected));
    c_ph1: cover property (i_phase1[*6]);
endmodule
bind psr_rom psr_rom_chk i_psr_rom_chk (.*);
`default_nettype wire

/* psr_host.sv */
// Host read driver
`timescale 1ns/100ps
`default_nettype none
module psr_host (
    input wire logic i_clock,
    output logic [1:0] o_ph,
    output logic [10:0] o_adr,
    output logic [3:0] o_cs
);
    initial {o_ph, o_adr, o_cs} <= '0;
    task automatic read(input logic [10:0] a, input logic [3:0] s);
        @(posedge i_clock);
        {o_ph, o_adr, o_cs} <= {2'b10, a, s};
        repeat (6) @(posedge i_clock);
        o_ph <= 2'b01;
        repeat (6) @(posedge i_clock);
        {o_ph, o_adr} <= {2'b00, ~a};
        repeat (6) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

/* programmable_select_rom_tb_top.sv */
// Select ROM bench
`timescale 1ns/100ps
`default_nettype none
module programmable_select_rom_tb_top;
    import psr_pkg::*;
    // Reset starts unknown so the drop to zero is a real falling edge
    logic clk = 1'b0, nrst, hit, hit2;
    logic [3:0] d2;
    logic [1:0] ph;
    logic [10:0] a;
    logic [3:0] s, d;
    int fail_count = 0, checked = 0;
    initial forever #5 clk = ~clk;
    psr_host i_psr_host (.i_clock(clk), .o_ph(ph), .o_adr(a), .o_cs(s));
    psr_rom #(.SELECT_CODE(4'ha), .SELECT_IGNORED(3'h1), .RANDOM_CONTENT(1'b0))
        i_psr_rom (.i_clock(clk), .i_nrst(nrst), .i_address(a), .o_data(d),
        .i_phase1(ph[1]), .i_phase2(ph[0]), .o_selected(hit),
        .i_select_code_bit_first(s[3]), .i_select_code_bit_second(s[2]),
        .i_select_code_bit_third(s[1]), .i_select_code_bit_fourth(s[0]));
    // Always-selected part with the standard random content
    if (1)
    begin : g_rand
        psr_rom #(.SELECT_CODE(4'h5), .SELECT_IGNORED(3'h4),
            .RANDOM_CONTENT(1'b1))
            i_psr_rom (.i_clock(clk), .i_nrst(nrst), .i_address(a),
            .o_data(d2), .i_phase1(ph[1]), .i_phase2(ph[0]),
            .o_selected(hit2),
            .i_select_code_bit_first(s[3]),
            .i_select_code_bit_second(s[2]),
            .i_select_code_bit_third(s[1]),
            .i_select_code_bit_fourth(s[0]));
    end
    // Word i is the low nibble after i+1 LFSR steps from the seed
    function automatic logic [3:0] rand_word(input int idx);
        logic [15:0] r;
        r = PSR_LFSR_SEED;
        for (int k = 0; k <= idx; k++)
            r = r[0] ? ((r >> 1) ^ PSR_LFSR_TAPS) : (r >> 1);
        return r[3:0];
    endfunction
    task automatic check(input logic [3:0] v, input logic [3:0] e);
        checked++;
        fail_count += int'(v !== e);
        if (v !== e) $display("MISMATCH %0t bad data", $time);
    endtask
    task automatic results(input int x);
        fail_count += x;
        $display("%0d of %0d bad", fail_count, checked);
        if (!fail_count && checked)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic t_sel();
        for (int b = 0; b < 5; b++)
        begin
            i_psr_host.read(11'h7fb + 11'(b), 4'ha ^ (4'h1 << b));
            check(d, (b < 3) ? 4'h0 : 4'(11 + b));
            check(4'(hit), 4'(b > 2));
            check(4'(hit2), 4'h1);
        end
    endtask
    task automatic t_rand();
        for (int b = 0; b < 3; b++)
        begin
            i_psr_host.read(11'(b * 700), 4'(b));
            check(d2, rand_word(b * 700));
            check(4'(hit2), 4'h1);
        end
    endtask
    initial
    begin
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_sel();
        t_rand();
        results(0);
    end
    initial #20us results(1);
endmodule
`default_nettype wire
